/* hw/video_reference_failover.sv */
// video reference failover: staged standard config, conversion checks,
// reference mismatch warnings, primary/secondary failover with delay
// and phase difference monitor.
// assumes source status and reference edges arrive asynchronously.
`timescale 1ns/1ns
`default_nettype none

module video_reference_failover #(
  parameter int SEC_CYC = vref_pkg::CLK_HZ // cycles per second
) (
  input  wire logic               mclk_i,        // 25 MHz clock
  input  wire logic               rst_n_i,       // sync reset, low
  input  wire logic [3:0]         avs_address,   // byte address
  input  wire logic               avs_read,      // read strobe
  input  wire logic               avs_write,     // write strobe
  input  wire logic [31:0]        avs_writedata, // write data
  input  wire logic [3:0]         avs_byteenable,// byte lanes
  output logic [31:0]             avs_readdata,  // read data
  output logic                    avs_waitrequest, // stall
  input  wire vref_pkg::src_stat_t src_i [4],    // async source status
  input  wire logic [3:0]         det_std_i,     // async detected std
  input  wire logic               marker_i,      // async 10-field mark
  input  wire logic [3:0]         ref_edge_i,    // async ref frame edges
  input  wire logic [23:0]        video_i,       // converted video
  input  wire logic [23:0]        bars_i,        // colorbar generator
  output logic [23:0]             video_o,       // output video
  output logic [1:0]              timing_sel_o,  // active timing src
  output logic [1:0]              conv_o,        // active conversion
  output logic                    busy_o,        // reconfiguring
  output logic                    cfg_err_o,     // config error
  output logic                    mismatch_o     // ref mismatch
);

  typedef enum logic [2:0] {
    FS_PRI  = 3'b001,
    FS_SEC  = 3'b010,
    FS_WAIT = 3'b100
  } fo_state_t;

  // two-stage synchronisers for all async inputs
  logic [23:0] stat_s1_r, stat_s2_r;
  logic [3:0]  det_s1_r, det_s2_r, edge_s1_r, edge_s2_r, edge_d_r;
  logic        mk_s1_r, mk_s2_r;
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      stat_s1_r <= 24'h0;
      stat_s2_r <= 24'h0;
      det_s1_r  <= 4'h0;
      det_s2_r  <= 4'h0;
      edge_s1_r <= 4'h0;
      edge_s2_r <= 4'h0;
      edge_d_r  <= 4'h0;
      mk_s1_r   <= 1'b0;
      mk_s2_r   <= 1'b0;
    end
    else
    begin
      stat_s1_r <= {src_i[3], src_i[2], src_i[1], src_i[0]};
      stat_s2_r <= stat_s1_r;
      det_s1_r  <= det_std_i;
      det_s2_r  <= det_s1_r;
      edge_s1_r <= ref_edge_i;
      edge_s2_r <= edge_s1_r;
      edge_d_r  <= edge_s2_r;
      mk_s1_r   <= marker_i;
      mk_s2_r   <= mk_s1_r;
    end
  end

  vref_pkg::src_stat_t st [4];
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      st[i] = stat_s2_r[i*6 +: 6];
  end

  // a source is usable when present, locked and valid
  function automatic logic good(input vref_pkg::src_stat_t s);
    good = s.present & s.locked & s.valid;
  endfunction : good

  // frame rate family: 1 for 50 Hz based standards
  function automatic logic fam50(input logic [3:0] s);
    fam50 = (s == vref_pkg::STD_576I) || (s == vref_pkg::STD_1080I50)
            || (s == vref_pkg::STD_720P50);
  endfunction : fam50

  function automatic logic is_hd(input logic [3:0] s);
    is_hd = (s != vref_pkg::STD_480I) && (s != vref_pkg::STD_576I);
  endfunction : is_hd

  // registers
  logic [3:0] pend_in_r, pend_out_r, act_in_r, act_out_r;
  logic       test_r, auto_r, back_req_r;
  logic [1:0] pri_r, sec_r;
  logic [7:0] dly_s_r;
  logic       refuse_r;
  logic [4:0] reconf_r;
  logic [3:0] eff_in;
  logic       wr_cfg, wr_tim, do_apply;

  assign wr_cfg   = avs_write && avs_address == vref_pkg::ADDR_CFG;
  assign wr_tim   = avs_write && avs_address == vref_pkg::ADDR_TIMING;
  assign do_apply = wr_cfg && avs_byteenable[1]
                    && avs_writedata[vref_pkg::CFG_APPLY];
  // reads take one wait state so the registered data stands when
  // waitrequest drops; writes land at once
  logic rd_done_r;
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      rd_done_r <= 1'b0;
    else
      rd_done_r <= avs_read && !rd_done_r;
  end
  assign avs_waitrequest = avs_read && !rd_done_r;

  // auto input takes the detected standard
  assign eff_in = (act_in_r == vref_pkg::STD_AUTO) ? det_s2_r
                  : act_in_r;

  // conversion from output against input
  function automatic logic [1:0] conv_of(input logic [3:0] i,
                                          input logic [3:0] o);
    if (i == o)
      conv_of = vref_pkg::CONV_PASS;
    else if (!is_hd(i) && is_hd(o))
      conv_of = vref_pkg::CONV_UP;
    else if (is_hd(i) && !is_hd(o))
      conv_of = vref_pkg::CONV_DOWN;
    else
      conv_of = vref_pkg::CONV_CROSS;
  endfunction : conv_of

  logic [3:0] ap_in;
  logic       bad_pair;
  assign ap_in = (pend_in_r == vref_pkg::STD_AUTO) ? det_s2_r : pend_in_r;
  // down conversion across 59.94 and 50 families is refused
  assign bad_pair = conv_of(ap_in, pend_out_r) == vref_pkg::CONV_DOWN
                    && fam50(ap_in) != fam50(pend_out_r);

  // pending and committed standards
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pend_in_r  <= vref_pkg::RST_IN_STD;
      pend_out_r <= vref_pkg::RST_OUT_STD;
      act_in_r   <= vref_pkg::RST_IN_STD;
      act_out_r  <= vref_pkg::RST_OUT_STD;
      test_r     <= 1'b0;
      refuse_r   <= 1'b0;
    end
    else if (do_apply && reconf_r == 5'h0)
    begin
      if (bad_pair)
        refuse_r <= 1'b1;
      else
      begin
        act_in_r  <= pend_in_r;
        act_out_r <= pend_out_r;
        refuse_r  <= 1'b0;
      end
    end
    else if (wr_cfg && avs_byteenable[0])
    begin
      pend_in_r  <= avs_writedata[vref_pkg::CFG_IN_LSB +: 4];
      pend_out_r <= avs_writedata[vref_pkg::CFG_OUT_LSB +: 4];
    end
    if (rst_n_i && wr_cfg && avs_byteenable[1])
      test_r <= avs_writedata[vref_pkg::CFG_TEST_BIT];
  end

  // reconfiguration busy counter for up and down conversion
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      reconf_r <= 5'h0;
    else if (do_apply && reconf_r == 5'h0 && !bad_pair
             && conv_of(ap_in, pend_out_r) inside
                {vref_pkg::CONV_UP, vref_pkg::CONV_DOWN})
      reconf_r <= 5'(vref_pkg::RECONF_CYC);
    else if (reconf_r != 5'h0)
      reconf_r <= reconf_r - 5'h1;
  end
  assign busy_o = reconf_r != 5'h0;
  assign conv_o = conv_of(eff_in, act_out_r);

  // test pattern replaces the video, registered
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      video_o <= 24'h0;
    else
      video_o <= test_r ? bars_i : video_i;
  end

  // timing config register
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pri_r   <= vref_pkg::SRC_LOCAL;
      sec_r   <= vref_pkg::SRC_LOCAL;
      auto_r  <= 1'b1;
      dly_s_r <= vref_pkg::RST_DLY_S;
    end
    else if (wr_tim)
    begin
      if (avs_byteenable[0])
      begin
        pri_r  <= avs_writedata[vref_pkg::TIM_PRI_LSB +: 2];
        sec_r  <= avs_writedata[vref_pkg::TIM_SEC_LSB +: 2];
        auto_r <= avs_writedata[vref_pkg::TIM_AUTO_BIT];
      end
      if (avs_byteenable[1])
        // clamp keeps the delay at or above its floor
        dly_s_r <= (avs_writedata[15:8] < 8'(vref_pkg::MIN_DLY_S))
                   ? 8'(vref_pkg::MIN_DLY_S)
                   : avs_writedata[15:8];
    end
  end
  assign back_req_r = wr_tim && avs_byteenable[0]
                      && avs_writedata[vref_pkg::TIM_BACK_BIT];

  // failover state machine
  fo_state_t  fs_r;
  logic [25:0] sub_r;
  logic [7:0]  sec_cnt_r;
  logic        pri_ok, fo_en;
  assign pri_ok = good(st[pri_r]);
  assign fo_en  = pri_r != sec_r;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      fs_r      <= FS_PRI;
      sub_r     <= 26'h0;
      sec_cnt_r <= 8'h0;
    end
    else
    begin
      case (fs_r)
        FS_PRI:
          if (fo_en && !pri_ok)
            fs_r <= FS_SEC;
        FS_SEC:
          if (!fo_en)
            fs_r <= FS_PRI;
          else if (pri_ok && !auto_r && back_req_r)
            fs_r <= FS_PRI;
          else if (pri_ok && auto_r)
          begin
            fs_r      <= FS_WAIT;
            sub_r     <= 26'h0;
            sec_cnt_r <= 8'h0;
          end
        FS_WAIT:
          if (!fo_en)
            fs_r <= FS_PRI;
          else if (!pri_ok)
            fs_r <= FS_SEC;
          else if (sec_cnt_r >= dly_s_r)
            fs_r <= FS_PRI;
          else if (sub_r == 26'(SEC_CYC - 1))
          begin
            sub_r     <= 26'h0;
            sec_cnt_r <= sec_cnt_r + 8'h1;
          end
          else
            sub_r <= sub_r + 26'h1;
        default:
          fs_r <= FS_PRI;
      endcase
    end
  end
  // both buses switch in the same cycle; locked sources keep genlock
  assign timing_sel_o = (fs_r == FS_PRI) ? pri_r : sec_r;

  // reference mismatch check against the active output standard
  vref_pkg::src_stat_t ref_s;
  logic                mm;
  assign ref_s = st[timing_sel_o];
  always_comb
  begin
    mm = 1'b0;
    case (act_out_r)
      vref_pkg::STD_480I, vref_pkg::STD_1080I60:
        mm = ref_s.kind == vref_pkg::REF_TLS_P60;
      vref_pkg::STD_576I, vref_pkg::STD_1080I50:
        mm = ref_s.kind == vref_pkg::REF_TLS_P50;
      vref_pkg::STD_720P60, vref_pkg::STD_720P50:
        mm = 1'b0;
      vref_pkg::STD_1080P24, vref_pkg::STD_1080SF:
        // only NTSC composite with marker is safe; any other kind is a mismatch
        mm = (ref_s.kind == vref_pkg::REF_NTSC) ? !mk_s2_r
             : 1'b1;
      default:
        mm = 1'b0;
    endcase
  end
  assign mismatch_o = mm;
  assign cfg_err_o  = refuse_r | mm;

  // phase difference between primary and secondary frame edges
  logic [5:0] ph_cnt_r, ph_last_r;
  logic       ph_run_r;
  logic       e_pri, e_sec;
  assign e_pri = edge_s2_r[pri_r] & !edge_d_r[pri_r];
  assign e_sec = edge_s2_r[sec_r] & !edge_d_r[sec_r];
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      ph_cnt_r  <= 6'h0;
      ph_last_r <= 6'h0;
      ph_run_r  <= 1'b0;
    end
    else if (e_pri && e_sec)
    begin
      ph_last_r <= 6'h0;
      ph_run_r  <= 1'b0;
    end
    else if (e_pri || e_sec)
    begin
      if (ph_run_r)
      begin
        ph_last_r <= ph_cnt_r;
        ph_run_r  <= 1'b0;
      end
      else
      begin
        ph_cnt_r <= 6'h1;
        ph_run_r <= 1'b1;
      end
    end
    else if (ph_run_r)
    begin
      // saturate at the full scale of about one microsecond
      if (ph_cnt_r < 6'(vref_pkg::PHASE_FULL_CYC))
        ph_cnt_r <= ph_cnt_r + 6'h1;
      else
      begin
        ph_last_r <= ph_cnt_r;
        ph_run_r  <= 1'b0;
      end
    end
  end

  logic ph_ok, ph_big;
  assign ph_ok  = ph_last_r <= 6'(vref_pkg::PHASE_OK_CYC);
  assign ph_big = !ph_ok;

  // register read mux, zero for unmapped addresses
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      avs_readdata <= 32'h0;
    else if (avs_read && !rd_done_r)
      case (avs_address)
        vref_pkg::ADDR_CFG:
          avs_readdata <= {23'h0, test_r, act_out_r, act_in_r};
        vref_pkg::ADDR_TIMING:
          avs_readdata <= {16'h0, dly_s_r, 3'h0, auto_r, sec_r, pri_r};
        vref_pkg::ADDR_STATUS:
          avs_readdata <= {stat_s2_r, eff_in, timing_sel_o,
                           busy_o, refuse_r};
        vref_pkg::ADDR_PHASE:
          avs_readdata <= {24'h0, ph_big, ph_ok, ph_last_r};
        default:
          avs_readdata <= 32'h0;
      endcase
  end

  // checks
  property p_test_out;
    @(posedge mclk_i) disable iff (!rst_n_i)
      test_r |=> video_o == $past(bars_i);
  endproperty
  a_test_out: assert property (p_test_out)
    else $error("bars not on output");

  property p_pend;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !do_apply |=> $stable(act_out_r);
  endproperty
  a_pend: assert property (p_pend)
    else $error("output std changed without apply");

  property p_busy;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(busy_o) |-> busy_o [*8];
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy too short");

  property p_refuse;
    @(posedge mclk_i) disable iff (!rst_n_i)
      do_apply && reconf_r == 5'h0 && bad_pair |=> refuse_r && cfg_err_o;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("bad conversion not refused");

  property p_fail;
    @(posedge mclk_i) disable iff (!rst_n_i)
      fs_r == FS_PRI && fo_en && !pri_ok |=> timing_sel_o == sec_r;
  endproperty
  a_fail: assert property (p_fail)
    else $error("no failover");

  property p_same;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !fo_en |=> fs_r == FS_PRI;
  endproperty
  a_same: assert property (p_same)
    else $error("failover with equal sources");

  property p_delay;
    @(posedge mclk_i) disable iff (!rst_n_i)
      fs_r == FS_WAIT && fo_en ##1 fs_r == FS_PRI
        |-> $past(sec_cnt_r) >= 8'd30;
  endproperty
  a_delay: assert property (p_delay)
    else $error("switchback before thirty seconds");

  property p_refail;
    @(posedge mclk_i) disable iff (!rst_n_i)
      fs_r == FS_WAIT && fo_en && !pri_ok |=> fs_r == FS_SEC;
  endproperty
  a_refail: assert property (p_refail)
    else $error("refail not handled");

  c_fail: cover property (@(posedge mclk_i) fs_r == FS_SEC);
  c_back: cover property (@(posedge mclk_i)
                          fs_r == FS_WAIT ##1 fs_r == FS_PRI);
  c_busy: cover property (@(posedge mclk_i) $rose(busy_o));

endmodule : video_reference_failover

`default_nettype wire

/* hw/vref_pkg.sv */
// package for the video reference failover block: encodings, timing
// constants and carrier structs shared by design and bench.
// assumes a single 25 MHz clock domain and avalon-mm register access.
package vref_pkg;

  // standards (input and output share one code space)
  localparam logic [3:0] STD_480I    = 4'h0;
  localparam logic [3:0] STD_576I    = 4'h1;
  localparam logic [3:0] STD_1080I60 = 4'h2;
  localparam logic [3:0] STD_720P60  = 4'h3;
  localparam logic [3:0] STD_1080I50 = 4'h4;
  localparam logic [3:0] STD_720P50  = 4'h5;
  localparam logic [3:0] STD_1080P24 = 4'h6;
  localparam logic [3:0] STD_1080SF  = 4'h7;
  localparam logic [3:0] STD_AUTO    = 4'hf;

  // detected reference kinds
  localparam logic [2:0] REF_NONE    = 3'h0;
  localparam logic [2:0] REF_NTSC    = 3'h1;
  localparam logic [2:0] REF_PAL     = 3'h2;
  localparam logic [2:0] REF_TLS_I60 = 3'h3;
  localparam logic [2:0] REF_TLS_P60 = 3'h4;
  localparam logic [2:0] REF_TLS_I50 = 3'h5;
  localparam logic [2:0] REF_TLS_P50 = 3'h6;
  localparam logic [2:0] REF_TLS_24  = 3'h7;

  // conversion kind
  localparam logic [1:0] CONV_PASS  = 2'h0;
  localparam logic [1:0] CONV_UP    = 2'h1;
  localparam logic [1:0] CONV_DOWN  = 2'h2;
  localparam logic [1:0] CONV_CROSS = 2'h3;

  // timing source selection
  localparam logic [1:0] SRC_LOCAL = 2'h0;
  localparam logic [1:0] SRC_FIRST_FRAME_REFERENCE  = 2'h1;
  localparam logic [1:0] SRC_SECOND_FRAME_REFERENCE  = 2'h2;
  localparam logic [1:0] SRC_INPUT = 2'h3;

  // register byte addresses
  localparam logic [3:0] ADDR_CFG    = 4'h0;
  localparam logic [3:0] ADDR_TIMING = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_PHASE  = 4'hc;

  // cfg field positions
  localparam int CFG_IN_LSB   = 0;
  localparam int CFG_OUT_LSB  = 4;
  localparam int CFG_TEST_BIT = 8;
  localparam int CFG_APPLY    = 9;
  // timing field positions
  localparam int TIM_PRI_LSB  = 0;
  localparam int TIM_SEC_LSB  = 2;
  localparam int TIM_AUTO_BIT = 4;
  localparam int TIM_BACK_BIT = 5;
  localparam int TIM_DLY_LSB  = 8;

  // reset values
  localparam logic [3:0] RST_IN_STD  = STD_AUTO;
  localparam logic [3:0] RST_OUT_STD = STD_1080I60;
  localparam logic [7:0] RST_DLY_S   = 8'h1e;

  // times
  localparam int CLK_HZ        = 25000000;
  localparam int MIN_DLY_S     = 30;
  localparam int PHASE_OK_NS   = 72;
  localparam int PHASE_FULL_NS = 1000;
  localparam int CLK_NS        = 1000000000 / CLK_HZ;
  localparam int PHASE_OK_CYC  = (PHASE_OK_NS / CLK_NS) < 1 ? 1
                                 : PHASE_OK_NS / CLK_NS;
  localparam int PHASE_FULL_CYC = PHASE_FULL_NS / CLK_NS;
  localparam int RECONF_CYC    = 16;

  // per-source status carried into the block
  typedef struct packed {
    logic present;
    logic locked;
    logic valid;
    logic [2:0] kind;
  } src_stat_t;

endpackage : vref_pkg

/* dv/vref_source_model.sv */
// far-side model: genlock sources with status, kind and frame edges
// assumes the bench sets fault flags, kinds and edge offsets per source
`timescale 1ns/1ns
`default_nettype none
module vref_source_model (
  input  wire logic               mclk_i,    // system clock
  input  wire logic [2:0]         flag_i [4], // present, locked, valid
  input  wire logic [2:0]         kind_i [4], // detected reference kind
  input  wire logic [5:0]         off_i  [4], // edge offset in cycles
  input  wire logic               mark_en_i, // ten-field marker on
  output var vref_pkg::src_stat_t src_o  [4], // per-source status
  output var logic [3:0]          edge_o,    // frame edges
  output var logic                marker_o   // ten-field marker
);
  logic [5:0] frm_r = 6'h00; // frame counter, 64 cycles a frame

  // all sources share one frame, like buses locked to one reference;
  // the offset sets each source's phase, edges stay four cycles wide
  always_ff @(posedge mclk_i)
  begin
    frm_r <= frm_r + 6'h01;
    for (int i = 0; i < 4; i++)
    begin
      edge_o[i] <= (frm_r - off_i[i]) < 6'h04;
      src_o[i]  <= {flag_i[i], kind_i[i]};
    end
    marker_o <= mark_en_i;
  end
endmodule : vref_source_model
`default_nettype wire

/* dv/video_reference_failover_test.sv */
// self-checking bench for the reference failover block
// assumes package and design compiled first; short second for speed
`timescale 1ns/1ns
`default_nettype none
module video_reference_failover_test;
  localparam int SEC = 4; // cycles per second in simulation
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic        rds = 1'b0;
  logic        wrs = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'h0;
  logic [31:0] rdat;
  logic        wreq;
  vref_pkg::src_stat_t src [4];
  logic [3:0]  det = 4'h0;
  logic        mark;
  logic        mark_en = 1'b0;
  logic [3:0]  edges;
  logic [23:0] vid = 24'h0;
  logic [23:0] bars = 24'h0;
  logic [23:0] vo;
  logic [1:0]  sel;
  logic [1:0]  conv;
  logic        busy, err, mism, bz, ref_r;
  logic [2:0]  flag [4] = '{3'h7, 3'h7, 3'h7, 3'h7};
  logic [2:0]  kind [4] = '{3'h1, 3'h1, 3'h1, 3'h1};
  logic [5:0]  off [4] = '{6'h0, 6'h8, 6'h8, 6'h0};
  logic [3:0]  ain = vref_pkg::RST_IN_STD;
  logic [3:0]  aout = vref_pkg::RST_OUT_STD;
  int          error_cnt = 0;
  int          cmp_count = 0;

  // free-running 25 MHz clock
  always #20 mclk_i = ~mclk_i;

  video_reference_failover #(.SEC_CYC(SEC)) u_video_reference_failover (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address(addr),
    .avs_read(rds), .avs_write(wrs), .avs_writedata(wdat),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .src_i(src), .det_std_i(det), .marker_i(mark), .ref_edge_i(edges),
    .video_i(vid), .bars_i(bars), .video_o(vo), .timing_sel_o(sel),
    .conv_o(conv), .busy_o(busy), .cfg_err_o(err), .mismatch_o(mism));

  vref_source_model u_vref_source_model (
    .mclk_i(mclk_i), .flag_i(flag), .kind_i(kind), .off_i(off),
    .mark_en_i(mark_en), .src_o(src), .edge_o(edges), .marker_o(mark));

  task results();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // bus master: hold the request until waitrequest is seen low
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    addr <= a;
    wdat <= d;
    be   <= b;
    wrs  <= 1'b1;
    @(posedge mclk_i);
    while (wreq !== 1'b0) @(posedge mclk_i);
    wrs <= 1'b0;
    @(posedge mclk_i);
  endtask : wr

  // read data stands at the edge that sees waitrequest low; take it there
  task rd(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rds  <= 1'b1;
    @(posedge mclk_i);
    while (wreq !== 1'b0) @(posedge mclk_i);
    d = rdat;
    rds <= 1'b0;
    @(posedge mclk_i);
  endtask : rd

  // sd codes are 0 and 1 in the package
  function automatic logic [1:0] conv_exp(input logic [3:0] i, o);
    if (i == o) return vref_pkg::CONV_PASS;
    if (i < 4'h2 && o >= 4'h2) return vref_pkg::CONV_UP;
    if (i >= 4'h2 && o < 4'h2) return vref_pkg::CONV_DOWN;
    return vref_pkg::CONV_CROSS;
  endfunction : conv_exp

  // 23.98 standards belong to the 59.94 family
  function automatic int fam(input logic [3:0] s);
    case (s)
      vref_pkg::STD_576I, vref_pkg::STD_1080I50, vref_pkg::STD_720P50:
        return 1;
      default: return 0;
    endcase
  endfunction : fam

  // only same-rate references are offered to the 720p outputs
  function automatic logic mis_exp(input logic [3:0] o,
                                   input logic [2:0] k, input logic m);
    case (o)
      vref_pkg::STD_480I, vref_pkg::STD_1080I60:
        return k == vref_pkg::REF_TLS_P60;
      vref_pkg::STD_576I, vref_pkg::STD_1080I50:
        return k == vref_pkg::REF_TLS_P50;
      vref_pkg::STD_720P60, vref_pkg::STD_720P50: return 1'b0;
      default: return !(k == vref_pkg::REF_NTSC && m);
    endcase
  endfunction : mis_exp

  // stage standards, confirm nothing moved, then commit and wait out busy
  task apply(input logic [3:0] a, input logic [3:0] b);
    logic [31:0] d;
    logic [3:0]  e;
    wr(vref_pkg::ADDR_CFG, 32'({b, a}), 4'h1);
    rd(vref_pkg::ADDR_CFG, d);
    chk("pending", 32'({aout, ain}), 32'(d[7:0]));
    wr(vref_pkg::ADDR_CFG, 32'h0000_0200, 4'h2);
    bz = busy;
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge mclk_i);
    e = (a == vref_pkg::STD_AUTO) ? det : a;
    ref_r = conv_exp(e, b) == vref_pkg::CONV_DOWN && fam(e) != fam(b);
    if (!ref_r)
    begin
      ain  = a;
      aout = b;
    end
    repeat (4) @(posedge mclk_i);
  endtask : apply

  task wtim(input logic [1:0] p, s, input logic au, bk);
    wr(vref_pkg::ADDR_TIMING, 32'({8'h05, 2'h0, bk, au, s, p}), 4'h3);
  endtask : wtim

  task wsel(input logic [1:0] s, input int n);
    for (int i = 0; i < n && sel !== s; i++) @(posedge mclk_i);
    chk("sel", 32'(s), 32'(sel));
  endtask : wsel

  task hsel(input logic [1:0] s, input int n);
    logic [1:0] seen;
    seen = s;
    repeat (n)
    begin
      @(posedge mclk_i);
      if (sel !== s) seen = sel;
    end
    chk("sel held", 32'(s), 32'(seen));
  endtask : hsel

  // hang guard, well beyond the few thousand cycles the tests take
  initial
  begin
    repeat (30000) @(posedge mclk_i);
    error_cnt++;
    results();
  end

  // main sequence
  initial
  begin
    logic [31:0] d;
    logic [3:0]  a, b;
    logic        ok;
    int          dd, dexp;
    // 0 480i, 1 576i, 2 1080i60, 3 720p60, 4 1080i50, 6 1080p24, 7 sf
    static logic [3:0] ci [7] = '{4'h0, 4'h2, 4'h2, 4'h3, 4'h4, 4'h1, 4'h4};
    static logic [3:0] co [7] = '{4'h2, 4'h0, 4'h3, 4'h3, 4'h0, 4'h4, 4'h1};
    static logic [3:0] mo [8] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h3, 4'h6, 4'h6,
                                  4'h7};
    static logic [2:0] mk [8] = '{3'h1, 3'h4, 3'h2, 3'h6, 3'h3, 3'h3, 3'h1,
                                  3'h7};
    static logic [2:0] fl [3] = '{3'b011, 3'b101, 3'b110};
    void'($urandom(10));
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    wr(4'h2, 32'hffff_ffff, 4'hf);
    rd(vref_pkg::ADDR_CFG, d);
    chk("cfg", 32'({aout, ain}), d & 32'h0000_01ff);
    rd(vref_pkg::ADDR_TIMING, d);
    chk("timing", 32'({vref_pkg::RST_DLY_S, 8'h10}), d & 32'h0000_ff1f);
    repeat (2)
    begin
      vid  <= 24'($urandom);
      bars <= 24'($urandom);
      wr(vref_pkg::ADDR_CFG, 32'h0000_0100, 4'h2);
      @(posedge mclk_i);
      chk("bars out", 32'(bars), 32'(vo));
      wr(vref_pkg::ADDR_CFG, 32'h0, 4'h2);
      @(posedge mclk_i);
      chk("video out", 32'(vid), 32'(vo));
    end
    for (int k = 0; k < 10; k++)
    begin
      a = (k < 7) ? ci[k] : 4'($urandom_range(7));
      b = (k < 7) ? co[k] : 4'($urandom_range(7));
      apply(a, b);
      rd(vref_pkg::ADDR_STATUS, d);
      chk("refused", 32'(ref_r), 32'(d[0]));
      if (ref_r) chk("cfg err", 32'h1, 32'(err));
      if (!ref_r && conv_exp(a, b) inside {2'h1, 2'h2})
        chk("busy", 32'h1, 32'(bz));
      chk("conv", 32'(conv_exp(ain, aout)), 32'(conv));
    end
    apply(vref_pkg::STD_AUTO, vref_pkg::STD_1080I60);
    for (int k = 0; k < 8; k++)
    begin
      det <= 4'(k);
      repeat (6) @(posedge mclk_i);
      rd(vref_pkg::ADDR_STATUS, d);
      chk("detected", 32'(k), 32'(d[7:4]));
    end
    det <= 4'h0;
    for (int k = 0; k < 8; k++)
    begin
      kind[0] <= mk[k];
      mark_en <= (k == 6);
      apply(mo[k], mo[k]);
      chk("mismatch", 32'(mis_exp(mo[k], mk[k], k == 6)), 32'(mism));
      chk("err", 32'(mis_exp(mo[k], mk[k], k == 6)), 32'(err));
    end
    wtim(2'h1, 2'h2, 1'b1, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      dd = (k < 3) ? k : $urandom_range(20, 3);
      off[2] <= 6'(8 + dd);
      repeat (200) @(posedge mclk_i);
      rd(vref_pkg::ADDR_PHASE, d);
      ok = dd <= vref_pkg::PHASE_OK_CYC;
      chk("phase", 32'({!ok, ok, 6'(dd)}), 32'(d[7:0]));
    end
    off[2] <= 6'h8;
    dexp = vref_pkg::MIN_DLY_S * SEC; // programmed 5 s is below the floor
    for (int f = 0; f < 3; f++)
    begin
      flag[1] <= fl[f];
      wsel(2'h2, 12);
      rd(vref_pkg::ADDR_STATUS, d);
      chk("src status", 32'({fl[f], kind[1]}), 32'(d[19:14]));
      chk("status sel", 32'h2, 32'(d[3:2]));
      flag[1] <= 3'h7;
      hsel(2'h2, dexp - 10);
      wsel(2'h1, 30);
    end
    flag[1] <= 3'h0;
    wsel(2'h2, 12);
    flag[1] <= 3'h7;
    hsel(2'h2, 60);
    flag[1] <= 3'h0;
    hsel(2'h2, 8);
    flag[1] <= 3'h7;
    hsel(2'h2, dexp - 10);
    wsel(2'h1, 30);
    wtim(2'h1, 2'h2, 1'b0, 1'b0);
    flag[1] <= 3'h0;
    wsel(2'h2, 12);
    flag[1] <= 3'h7;
    hsel(2'h2, dexp + 20);
    wtim(2'h1, 2'h2, 1'b0, 1'b1);
    wsel(2'h1, 8);
    wtim(2'h1, 2'h1, 1'b1, 1'b0);
    flag[1] <= 3'h0;
    hsel(2'h1, 20);
    flag[1] <= 3'h7;
    for (int p = 0; p < 4; p++)
    begin
      wtim(2'(p), 2'(p), 1'b1, 1'b0);
      wsel(2'(p), 8);
    end
    results();
  end
endmodule : video_reference_failover_test
`default_nettype wire
